// ==== pkg/adcr_pkg.sv ====
// Purpose: Shared constants and types for the attached device clock/reset control
// Assumes: System clock of 200 MHz; all times converted to cycles here
// Notes: Long counts are defaults for top-level parameters so simulation can shorten them
package adcr_pkg;

	// System clock rate in kHz, used to turn times into cycle counts
	localparam int unsigned ADCR_CLK_KHZ = 200000;

	// Longest wait before the attached clock stops after suspend, per link type
	localparam int unsigned ADCR_HS_STOP_WAIT_MS = 50;
	localparam int unsigned ADCR_SS_STOP_WAIT_MS = 50;
	// Cycles from suspend seen to clock held low come off the wait, so the stop stays in the limit
	localparam int unsigned ADCR_STOP_LAT_CYC = 2;
	localparam int unsigned ADCR_HS_STOP_WAIT_CYC = ADCR_HS_STOP_WAIT_MS * ADCR_CLK_KHZ
		- ADCR_STOP_LAT_CYC;
	localparam int unsigned ADCR_SS_STOP_WAIT_CYC = ADCR_SS_STOP_WAIT_MS * ADCR_CLK_KHZ
		- ADCR_STOP_LAT_CYC;

	// Reset to the attached device ends this long after its clock starts (limit is 30 ms)
	localparam int unsigned ADCR_CLK_TO_RST_END_LIMIT_MS = 30;
	localparam int unsigned ADCR_RST_HOLD_US = 100;
	localparam int unsigned ADCR_RST_HOLD_CYC = (ADCR_RST_HOLD_US * ADCR_CLK_KHZ) / 1000;

	// Half period of the attached clock in system cycles
	localparam logic [7:0] ADCR_CLK_HALF_CYC = 8'h04;

	// Codes of the attached device type input
	localparam logic [1:0] ADCR_DEV_HS = 2'h0;
	localparam logic [1:0] ADCR_DEV_SS = 2'h1;
	localparam logic [1:0] ADCR_DEV_SS_HUB = 2'h2;

	// Values after reset
	localparam logic [31:0] ADCR_CNT_RST = 32'h0000_0000;
	localparam logic [7:0] ADCR_DIV_RST = 8'h00;

	// Control sequence states
	typedef enum logic [2:0] {
		ADCR_ST_POR,
		ADCR_ST_WARM,
		ADCR_ST_RUN,
		ADCR_ST_WAIT,
		ADCR_ST_STOP
	} adcr_state_e;

endpackage

// ==== pkg/adcr_tmr_if.sv ====
// Purpose: Control and status of one interval timer
// Assumes: Single clock domain shared by both ends
// Notes: Clear takes priority over run inside the timer
`timescale 1ns/1ps
`default_nettype none
interface adcr_tmr_if;
	logic run; // Count while high
	logic clr; // Restart count from zero
	logic done; // Interval elapsed
	modport ctl (output run, output clr, input done);
	modport tmr (input run, input clr, output done);
endinterface
`default_nettype wire

// ==== hdl/adcr_timer.sv ====
// Purpose: Interval timer that flags when a cycle limit is reached
// Assumes: Limit of at least one cycle
// Notes: Count saturates at the limit so done stays high until cleared
`timescale 1ns/1ps
`default_nettype none
module adcr_timer
	import adcr_pkg::*;
#(
	parameter int unsigned LIMIT = 1
) (
	input wire logic clk_sys_i, // System clock
	input wire logic nrst_i, // Async reset, active low
	adcr_tmr_if.tmr tmr // Timer control and status
);
	logic [31:0] cnt_q;
	logic [31:0] cnt_d;
	localparam logic [31:0] LIMIT_W = LIMIT[31:0];

	// Clear wins; count only until the limit to avoid wrapping
	always_comb begin
		cnt_d = cnt_q;
		if (tmr.clr) begin
			cnt_d = ADCR_CNT_RST;
		end else if (tmr.run && (cnt_q < LIMIT_W)) begin
			cnt_d = cnt_q + 32'h0000_0001;
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cnt_q <= ADCR_CNT_RST;
		end else begin
			cnt_q <= cnt_d;
		end
	end

	assign tmr.done = (cnt_q >= LIMIT_W) && !tmr.clr;
endmodule
`default_nettype wire

// ==== hdl/adcr_top.sv ====
// Purpose: Reset and clock output control for a non-removable device on port 1
// Assumes: All link status inputs are synchronous to clk_sys_i
// Notes: Attached clock is a divided system clock; its pin may carry suspend status instead
`timescale 1ns/1ps
`default_nettype none
//
// Operation
// (RULE_01) Reset source holds power-on reset at least 10 ms after supplies settle.
// (RULE_02) Attached clock starts within 300 us after the reset phase ends.
// (RULE_03) Reset output to attached device ends within 30 ms of clock start.
// (RULE_04) One pin carries either attached clock or suspend status, selected.
// (RULE_05) Clock stops on suspend only when the stop setting is enabled.
// (RULE_06) USB 2.0 attached device: stop clock after suspend wait, at most 50 ms.
// (RULE_07) USB 3.0 non-hub device: stop clock after suspend wait, at most 50 ms.
// (RULE_08) USB 3.0 hub: stop only after both suspend waits elapsed.
// (RULE_09) USB 2.0 resume during the wait cancels the pending stop.
// (RULE_10) USB 3.0 U3 exit during the wait cancels the pending stop.
// (RULE_11) Restart stopped clock within 1 ms of USB 2.0 port resume.
// (RULE_12) Restart within 1 ms after USB 2.0 port leaves suspend.
// (RULE_13) Restart within 1 ms after USB 2.0 upstream leaves suspend.
// (RULE_14) Restart within 1 ms of USB 3.0 port U3 exit.
// (RULE_15) Restart within 1 ms after USB 3.0 port leaves suspend.
// (RULE_16) Restart triggers are chosen by attached device type.
// (RULE_17) System clock source supplies 24 MHz, 100 ppm, 40 to 60 percent duty. Wait counts here assume a 200 MHz system clock.
// (RULE_18) Wait timers count system clocks and clear on cancel or restart.
// (RULE_19) During power-on reset clock stays stopped and reset output asserted.
module adcr_top
	import adcr_pkg::*;
#(
	parameter int unsigned HS_STOP_WAIT_CYC = ADCR_HS_STOP_WAIT_CYC,
	parameter int unsigned SS_STOP_WAIT_CYC = ADCR_SS_STOP_WAIT_CYC,
	parameter int unsigned RST_HOLD_CYC = ADCR_RST_HOLD_CYC
) (
	input wire logic clk_sys_i, // System clock
	input wire logic nrst_i, // Power-on reset, active low
	input wire logic [1:0] dev_type_i, // Attached device type code
	input wire logic pin_sel_clk_i, // 1: pin carries clock, 0: suspend status
	input wire logic clk_stop_en_i, // Nonvolatile setting allowing clock stop
	input wire logic suspend_indicator_i, // Hub suspend status to show on pin
	input wire logic hs_port_susp_i, // USB 2.0 port 1 suspended level
	input wire logic ss_port_susp_i, // USB 3.0 port 1 in U3 level
	input wire logic upstream_susp_i, // USB 2.0 upstream suspended level
	input wire logic hs_resume_i, // Pulse: resume sent or seen on USB 2.0 port 1
	input wire logic ss_u3_exit_i, // Pulse: U3 exit sent or seen on USB 3.0 port 1
	output logic attached_dev_clock_out_o, // Shared clock / suspend pin
	output logic attached_dev_reset_out_n_o, // Reset to attached device, active low
	output logic clk_running_o // Attached clock is toggling
);
	adcr_state_e state_q;
	adcr_state_e state_d;
	logic [7:0] div_q;
	logic [7:0] div_d;
	logic clk_q;
	logic clk_d;
	logic pin_q;
	logic pin_d;
	logic rst_n_q;
	logic rst_n_d;
	logic cancel_q;
	logic cancel_d;
	logic hs_susp_prev_q;
	logic ss_susp_prev_q;
	logic up_susp_prev_q;
	logic is_hs;
	logic is_ss;
	logic is_hub;
	logic use_hs;
	logic use_ss;
	logic susp_now;
	logic wait_done;
	logic cancel_evt;
	logic restart_evt;
	logic clk_on;

	adcr_tmr_if rst_tmr ();
	adcr_tmr_if hs_tmr ();
	adcr_tmr_if ss_tmr ();

	// Reset hold after clock start
	adcr_timer #(.LIMIT(RST_HOLD_CYC)) u_rst_tmr (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.tmr(rst_tmr)
	);

	// USB 2.0 suspend wait
	adcr_timer #(.LIMIT(HS_STOP_WAIT_CYC)) u_hs_tmr (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.tmr(hs_tmr)
	);

	// USB 3.0 suspend wait
	adcr_timer #(.LIMIT(SS_STOP_WAIT_CYC)) u_ss_tmr (
		.clk_sys_i(clk_sys_i),
		.nrst_i(nrst_i),
		.tmr(ss_tmr)
	);

	// Device type decides which link sides matter; unknown codes act as a hub
	always_comb begin
		is_hs = (dev_type_i == ADCR_DEV_HS);
		is_ss = (dev_type_i == ADCR_DEV_SS);
		is_hub = !is_hs && !is_ss;
		use_hs = is_hs || is_hub; // see (RULE_16)
		use_ss = is_ss || is_hub; // see (RULE_16)
	end

	// Suspend condition and combined wait completion
	always_comb begin
		if (is_hub) begin
			susp_now = hs_port_susp_i && ss_port_susp_i;
			wait_done = hs_tmr.done && ss_tmr.done; // see (RULE_08)
		end else if (is_ss) begin
			susp_now = ss_port_susp_i;
			wait_done = ss_tmr.done; // see (RULE_07)
		end else begin
			susp_now = hs_port_susp_i;
			wait_done = hs_tmr.done; // see (RULE_06)
		end
	end

	// Cancel and restart events, filtered by device type
	always_comb begin
		cancel_evt = (use_hs && hs_resume_i) // see (RULE_09)
			|| (use_ss && ss_u3_exit_i); // see (RULE_10)
		restart_evt = (use_hs && hs_resume_i) // see (RULE_11)
			|| (use_hs && hs_susp_prev_q && !hs_port_susp_i) // see (RULE_12)
			|| (use_hs && up_susp_prev_q && !upstream_susp_i) // see (RULE_13)
			|| (use_ss && ss_u3_exit_i) // see (RULE_14)
			|| (use_ss && ss_susp_prev_q && !ss_port_susp_i); // see (RULE_15)
	end

	// Timer control; any cancel or restart clears the waits
	always_comb begin
		rst_tmr.run = (state_q == ADCR_ST_WARM);
		rst_tmr.clr = (state_q != ADCR_ST_WARM);
		hs_tmr.run = (state_q == ADCR_ST_WAIT) && hs_port_susp_i;
		ss_tmr.run = (state_q == ADCR_ST_WAIT) && ss_port_susp_i;
		hs_tmr.clr = (state_q != ADCR_ST_WAIT) || cancel_evt || restart_evt; // see (RULE_18)
		ss_tmr.clr = (state_q != ADCR_ST_WAIT) || cancel_evt || restart_evt; // see (RULE_18)
	end

	// Sequence next state; cancel latch blocks a new wait until suspend ends
	always_comb begin
		state_d = state_q;
		rst_n_d = rst_n_q;
		cancel_d = cancel_q;
		if (!susp_now) begin
			cancel_d = 1'b0;
		end
		case (state_q)
			ADCR_ST_POR: begin
				state_d = ADCR_ST_WARM; // see (RULE_02)
			end
			ADCR_ST_WARM: begin
				if (rst_tmr.done) begin
					rst_n_d = 1'b1; // see (RULE_03)
					state_d = ADCR_ST_RUN;
				end
			end
			ADCR_ST_RUN: begin
				if (clk_stop_en_i && susp_now && !cancel_q) begin // see (RULE_05)
					state_d = ADCR_ST_WAIT;
				end
			end
			ADCR_ST_WAIT: begin
				if (cancel_evt || restart_evt) begin
					cancel_d = 1'b1; // see (RULE_09)
					state_d = ADCR_ST_RUN;
				end else if (!clk_stop_en_i || !susp_now) begin
					state_d = ADCR_ST_RUN;
				end else if (wait_done) begin
					state_d = ADCR_ST_STOP;
				end
			end
			ADCR_ST_STOP: begin
				if (restart_evt || !clk_stop_en_i) begin
					cancel_d = 1'b1; // Keep running if still suspended
					state_d = ADCR_ST_RUN;
				end
			end
			default: begin
				state_d = ADCR_ST_POR;
			end
		endcase
	end

	// Clock divider; stopping resets the phase so restart begins low
	always_comb begin
		clk_on = (state_d == ADCR_ST_WARM) || (state_d == ADCR_ST_RUN)
			|| (state_d == ADCR_ST_WAIT);
		div_d = div_q;
		clk_d = clk_q;
		if (!clk_on) begin
			div_d = ADCR_DIV_RST;
			clk_d = 1'b0;
		end else if (div_q >= (ADCR_CLK_HALF_CYC - 8'h01)) begin
			div_d = ADCR_DIV_RST;
			clk_d = !clk_q;
		end else begin
			div_d = div_q + 8'h01;
		end
		pin_d = pin_sel_clk_i ? clk_d : suspend_indicator_i; // see (RULE_04)
	end

	// All state held in reset while power-on reset is low
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			state_q <= ADCR_ST_POR; // see (RULE_19)
			rst_n_q <= 1'b0; // see (RULE_19)
			clk_q <= 1'b0;
			div_q <= ADCR_DIV_RST;
			pin_q <= 1'b0;
			cancel_q <= 1'b0;
			hs_susp_prev_q <= 1'b0;
			ss_susp_prev_q <= 1'b0;
			up_susp_prev_q <= 1'b0;
		end else begin
			state_q <= state_d;
			rst_n_q <= rst_n_d;
			clk_q <= clk_d;
			div_q <= div_d;
			pin_q <= pin_d;
			cancel_q <= cancel_d;
			hs_susp_prev_q <= hs_port_susp_i;
			ss_susp_prev_q <= ss_port_susp_i;
			up_susp_prev_q <= upstream_susp_i;
		end
	end

	assign attached_dev_clock_out_o = pin_q;
	assign attached_dev_reset_out_n_o = rst_n_q;
	assign clk_running_o = (state_q == ADCR_ST_WARM) || (state_q == ADCR_ST_RUN)
		|| (state_q == ADCR_ST_WAIT);
endmodule
`default_nettype wire

// ==== tb/adcr_props.sv ====
// Purpose: Port checker for adcr_top
// Assumes: Small wait parameters in simulation
// Notes: Stop bound skips waits that a cancel or restart has voided
`timescale 1ns/1ps
`default_nettype none
module adcr_props
	import adcr_pkg::*;
#(
	parameter int unsigned HS_STOP_WAIT_CYC = 20,
	parameter int unsigned SS_STOP_WAIT_CYC = 20,
	parameter int unsigned RST_HOLD_CYC = 10
) (
	input wire logic clk_sys_i, // Clock
	input wire logic nrst_i, // Reset
	input wire logic [1:0] dev_type_i, // Type
	input wire logic pin_sel_clk_i, // Pin mode
	input wire logic clk_stop_en_i, // Stop enable
	input wire logic suspend_indicator_i, // Status
	input wire logic hs_port_susp_i, // HS suspend
	input wire logic ss_port_susp_i, // SS suspend
	input wire logic upstream_susp_i, // Up suspend
	input wire logic hs_resume_i, // HS resume
	input wire logic ss_u3_exit_i, // U3 exit
	input wire logic attached_dev_clock_out_o, // Pin
	input wire logic attached_dev_reset_out_n_o, // Reset out
	input wire logic clk_running_o // Running
);
	localparam int RB = RST_HOLD_CYC + 4;
	localparam int LIM = (HS_STOP_WAIT_CYC > SS_STOP_WAIT_CYC ? HS_STOP_WAIT_CYC :
		SS_STOP_WAIT_CYC) + 6;
	logic sc;
	logic canc_d;
	logic canc_q;
	logic up_q;
	logic [31:0] cnt_d;
	logic [31:0] cnt_q;
	// Cycles spent running in an unvoided suspend wait; only events honoured for the type void it
	always_comb begin
		sc = dev_type_i[1] ? (hs_port_susp_i && ss_port_susp_i) :
			(dev_type_i[0] ? ss_port_susp_i : hs_port_susp_i);
		canc_d = sc && (canc_q || !clk_running_o
			|| (up_q && !upstream_susp_i && dev_type_i != ADCR_DEV_SS)
			|| (hs_resume_i && dev_type_i != ADCR_DEV_SS)
			|| (ss_u3_exit_i && dev_type_i != ADCR_DEV_HS));
		cnt_d = (sc && !canc_d && clk_stop_en_i && clk_running_o) ? cnt_q + 32'h1 : 32'h0;
	end
	// Registers only
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			canc_q <= 1'b0;
			up_q <= 1'b0;
			cnt_q <= 32'h0;
		end else begin
			canc_q <= canc_d;
			up_q <= upstream_susp_i;
			cnt_q <= cnt_d;
		end
	end
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!nrst_i);
	a_clk_starts: assert property (
		$rose(clk_running_o) && pin_sel_clk_i |-> ##[1:8] attached_dev_clock_out_o)
		else $error("clock pin idle");
	a_rst_after_clk: assert property (
		$rose(clk_running_o) && !attached_dev_reset_out_n_o |-> ##[1:RB] attached_dev_reset_out_n_o)
		else $error("reset out late");
	a_pin_select: assert property (
		!pin_sel_clk_i |=> attached_dev_clock_out_o == $past(suspend_indicator_i))
		else $error("pin not status");
	a_keep_on: assert property (
		clk_running_o && !clk_stop_en_i |=> clk_running_o)
		else $error("stop while disabled");
	a_stop_bound: assert property (
		cnt_q <= LIM) else $error("stop too late");
	a_hub_both: assert property (
		$fell(clk_running_o) && dev_type_i[1] |-> $past(hs_port_susp_i) && $past(ss_port_susp_i))
		else $error("hub stop early");
	a_resume_keeps: assert property (
		clk_running_o && hs_resume_i && dev_type_i != ADCR_DEV_SS |=> clk_running_o [*8])
		else $error("stop after resume");
	a_hs_restart: assert property (
		!clk_running_o && hs_resume_i && dev_type_i != ADCR_DEV_SS |-> ##[1:2] clk_running_o)
		else $error("no restart");
	a_u3_restart: assert property (
		!clk_running_o && ss_u3_exit_i && dev_type_i != ADCR_DEV_HS |-> ##[1:2] clk_running_o)
		else $error("no u3 restart");
	a_wake_restart: assert property (
		!clk_running_o && ((dev_type_i != ADCR_DEV_SS && ($fell(hs_port_susp_i) ||
		$fell(upstream_susp_i))) || (dev_type_i != ADCR_DEV_HS && $fell(ss_port_susp_i)))
		|-> ##[1:2] clk_running_o) else $error("no wake restart");
	a_pin_quiet: assert property (
		pin_sel_clk_i && !clk_running_o ##1 pin_sel_clk_i |-> !attached_dev_clock_out_o)
		else $error("pin toggles stopped");
	c_stop: cover property ($fell(clk_running_o));
	c_restart: cover property ($rose(clk_running_o) && attached_dev_reset_out_n_o);
	c_hub: cover property ($fell(clk_running_o) && dev_type_i[1]);
endmodule
`default_nettype wire

// ==== tb/adcr_dev_model.sv ====
// Purpose: Attached device on port 1
// Assumes: Pin in clock mode
// Notes: Behavioural; drives nothing back
`timescale 1ns/1ps
`default_nettype none
module adcr_dev_model (
	input wire logic dev_clk_i, // Clock pin from hub
	input wire logic dev_rst_n_i, // Reset from hub
	output var int pre_o // Edges seen while in reset
);
	// A device needs its clock before reset ends
	initial pre_o = 0;
	always @(posedge dev_clk_i) begin
		if (!dev_rst_n_i) begin
			pre_o <= pre_o + 1;
		end
	end
endmodule
`default_nettype wire

// ==== tb/test_adcr_top.sv ====
// Purpose: Self-checking bench for adcr_top
// Assumes: Shortened wait parameters
// Notes: Every check waits past the design's stated latency
`timescale 1ns/1ps
`default_nettype none
module test_adcr_top;
	import adcr_pkg::*;
	logic clk_sys_i, nrst_i, pin_sel_clk_i, clk_stop_en_i, suspend_indicator_i;
	logic hs_port_susp_i, ss_port_susp_i, upstream_susp_i, hs_resume_i, ss_u3_exit_i;
	logic [1:0] dev_type_i;
	logic attached_dev_clock_out_o, attached_dev_reset_out_n_o, clk_running_o;
	int pre_edges, n_tests, bad_count, cycles;
	adcr_top #(.HS_STOP_WAIT_CYC(20), .SS_STOP_WAIT_CYC(30), .RST_HOLD_CYC(10)) i_adcr_top (
		.clk_sys_i, .nrst_i, .dev_type_i, .pin_sel_clk_i, .clk_stop_en_i,
		.suspend_indicator_i, .hs_port_susp_i, .ss_port_susp_i, .upstream_susp_i,
		.hs_resume_i, .ss_u3_exit_i, .attached_dev_clock_out_o,
		.attached_dev_reset_out_n_o, .clk_running_o);
	adcr_dev_model i_adcr_dev_model (.dev_clk_i(attached_dev_clock_out_o),
		.dev_rst_n_i(attached_dev_reset_out_n_o), .pre_o(pre_edges));
	always #2.5 clk_sys_i = ~clk_sys_i;
	// Hang guard
	always @(posedge clk_sys_i) begin
		cycles++;
		if (cycles == 5000) begin
			bad_count++;
			complete_run();
		end
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s exp %0h seen %0h", what, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_i);
		#1;
	endtask
	task automatic susp(input logic [1:0] ty, input logic v);
		@(posedge clk_sys_i);
		dev_type_i <= ty;
		hs_port_susp_i <= v;
		ss_port_susp_i <= v;
		upstream_susp_i <= v;
	endtask
	// Leaving suspend must bring the clock back
	task automatic idle();
		susp(dev_type_i, 1'b0);
		cyc(10);
		check("running", clk_running_o, 1'b1);
	endtask
	// Stop, then one trigger; unused-type triggers leave it stopped
	task automatic t_wake(input logic [1:0] ty, input int tr, input logic ex);
		susp(ty, 1'b1);
		cyc(45);
		check("stopped", clk_running_o, 1'b0);
		check("pin low", attached_dev_clock_out_o, 1'b0);
		@(posedge clk_sys_i);
		case (tr)
			0: hs_resume_i <= 1'b1;
			1: hs_port_susp_i <= 1'b0;
			2: upstream_susp_i <= 1'b0;
			3: ss_u3_exit_i <= 1'b1;
			default: ss_port_susp_i <= 1'b0;
		endcase
		@(posedge clk_sys_i);
		hs_resume_i <= 1'b0;
		ss_u3_exit_i <= 1'b0;
		cyc(2);
		check("restart", clk_running_o, ex);
		idle();
		$display("end t_wake %0d %0d", ty, tr);
	endtask
	// Resume or U3 exit mid-wait voids the stop
	task automatic t_cancel(input logic [1:0] ty, input int tr);
		susp(ty, 1'b1);
		cyc(10);
		@(posedge clk_sys_i);
		hs_resume_i <= (tr == 0);
		ss_u3_exit_i <= (tr != 0);
		@(posedge clk_sys_i);
		hs_resume_i <= 1'b0;
		ss_u3_exit_i <= 1'b0;
		cyc(45);
		check("cancel", clk_running_o, 1'b1);
		idle();
		$display("end t_cancel");
	endtask
	// Hub stops only when the longer wait is over
	task automatic t_hub();
		susp(ADCR_DEV_SS_HUB, 1'b1);
		cyc(26);
		check("hub early", clk_running_o, 1'b1);
		cyc(12);
		check("hub stop", clk_running_o, 1'b0);
		idle();
		$display("end t_hub");
	endtask
	// Power-on reset mid-run stops the clock and holds the attached device in reset
	task automatic t_reset();
		@(posedge clk_sys_i);
		nrst_i <= 1'b0;
		cyc(3);
		check("reset clock", clk_running_o, 1'b0);
		check("reset out", attached_dev_reset_out_n_o, 1'b0);
		check("reset pin", attached_dev_clock_out_o, 1'b0);
		@(posedge clk_sys_i);
		nrst_i <= 1'b1;
		cyc(18);
		check("reset again", attached_dev_reset_out_n_o, 1'b1);
		$display("end t_reset");
	endtask
	// Clearing the setting restarts a stopped clock; no stop without it; pin may carry status
	task automatic t_misc();
		susp(ADCR_DEV_HS, 1'b1);
		cyc(45);
		check("stopped", clk_running_o, 1'b0);
		@(posedge clk_sys_i);
		clk_stop_en_i <= 1'b0;
		cyc(2);
		check("enable off", clk_running_o, 1'b1);
		idle();
		susp(ADCR_DEV_HS, 1'b1);
		cyc(45);
		check("no enable", clk_running_o, 1'b1);
		idle();
		@(posedge clk_sys_i);
		clk_stop_en_i <= 1'b1;
		pin_sel_clk_i <= 1'b0;
		suspend_indicator_i <= 1'b1;
		cyc(3);
		check("pin status", attached_dev_clock_out_o, 1'b1);
		@(posedge clk_sys_i);
		suspend_indicator_i <= 1'b0;
		cyc(3);
		check("pin status", attached_dev_clock_out_o, 1'b0);
		@(posedge clk_sys_i);
		pin_sel_clk_i <= 1'b1;
		$display("end t_misc");
	endtask
	task automatic complete_run();
		$display("Counts: %0d checks, %0d mismatches", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		{clk_sys_i, nrst_i, suspend_indicator_i, hs_port_susp_i, ss_port_susp_i} = 5'h00;
		{upstream_susp_i, hs_resume_i, ss_u3_exit_i, dev_type_i} = 5'h00;
		{n_tests, bad_count, cycles} = 96'h0;
		pin_sel_clk_i = 1'b1;
		clk_stop_en_i = 1'b1;
		cyc(1);
		check("por clock", clk_running_o, 1'b0);
		check("por reset", attached_dev_reset_out_n_o, 1'b0);
		repeat (2) @(posedge clk_sys_i);
		nrst_i <= 1'b1;
		cyc(18);
		check("reset end", attached_dev_reset_out_n_o, 1'b1);
		check("clk first", pre_edges > 0, 1'b1);
		$display("end power up");
		t_wake(ADCR_DEV_HS, 0, 1'b1);
		t_wake(ADCR_DEV_HS, 1, 1'b1);
		t_wake(ADCR_DEV_HS, 2, 1'b1);
		t_wake(ADCR_DEV_HS, 3, 1'b0);
		t_wake(ADCR_DEV_SS, 3, 1'b1);
		t_wake(ADCR_DEV_SS, 4, 1'b1);
		t_wake(ADCR_DEV_SS, 0, 1'b0);
		t_wake(ADCR_DEV_SS_HUB, 2, 1'b1);
		t_wake(ADCR_DEV_SS_HUB, 3, 1'b1);
		t_wake(2'h3, 4, 1'b1);
		t_cancel(ADCR_DEV_HS, 0);
		t_cancel(ADCR_DEV_SS, 1);
		t_hub();
		t_reset();
		t_misc();
		complete_run();
	end
endmodule
bind adcr_top adcr_props #(.HS_STOP_WAIT_CYC(HS_STOP_WAIT_CYC),
	.SS_STOP_WAIT_CYC(SS_STOP_WAIT_CYC), .RST_HOLD_CYC(RST_HOLD_CYC)) i_adcr_props (
	.clk_sys_i, .nrst_i, .dev_type_i, .pin_sel_clk_i, .clk_stop_en_i,
	.suspend_indicator_i, .hs_port_susp_i, .ss_port_susp_i, .upstream_susp_i,
	.hs_resume_i, .ss_u3_exit_i, .attached_dev_clock_out_o,
	.attached_dev_reset_out_n_o, .clk_running_o);
`default_nettype wire
